/* File: logic/srf_pkg.sv */
// Package for the serial report framer: constants and carrier types
package srf_pkg;

    // ****************************************
    // Frame constants
    // ****************************************
    localparam logic [7:0] SRF_START_CHAR = 8'h3a;  // Colon
    localparam logic [7:0] SRF_STATUS_OK = 8'h00;
    localparam logic [7:0] SRF_CMD_READING = 8'h00;
    localparam logic [7:0] SRF_CMD_DISPLAY = 8'h01;
    localparam logic [7:0] SRF_CMD_VALUES = 8'h02;
    localparam logic [7:0] SRF_CMD_LOOPS = 8'h03;
    localparam logic [7:0] SRF_LEN_READING = 8'h08;
    localparam logic [7:0] SRF_LEN_DISPLAY = 8'h0d;
    localparam logic [7:0] SRF_LEN_VALUES = 8'h08;
    localparam logic [7:0] SRF_LEN_LOOPS = 8'h08;
    localparam int SRF_PAYLOAD_MAX = 255;
    localparam int SRF_DATA_BITS = 8;
    localparam int SRF_STOP_BITS = 1;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SRF_CLK_HZ = 50_000_000;
    localparam logic [15:0] SRF_BAUD_DIV_RESET = 16'h01b1;  // 115200 baud

    // One payload byte offered to the framer
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } srf_byte_t;

    // Frame request
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] cmd;
        logic [7:0] count;
    } srf_req_t;

    // Measurement record supplying the four layouts
    typedef struct packed {
        logic [15:0] converter_reading;
        logic [31:0] oxygen_ppb;
        logic [15:0] range_index;
        logic [63:0] display_text;
        logic [7:0] flash_flag;
        logic [31:0] flash_mask;
        logic [31:0] temperature_c;
        logic [31:0] first_loop_value;
        logic [31:0] second_loop_value;
    } srf_meas_t;

endpackage

/* File: logic/srf_buf2.sv */
// Two-entry valid/ready buffer for transmit bytes
`timescale 1ns/1ps
`default_nettype none
module srf_buf2
    import srf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);
    typedef struct packed {
        logic [1:0][7:0] mem;
        logic rd;
        logic wr;
        logic [1:0] cnt;
    } srf_buf_st_t;

    srf_buf_st_t st, next_st;

    assign in_ready = (st.cnt != 2'd2);
    assign out_valid = (st.cnt != 2'd0);
    assign out_data = st.mem[st.rd];

    // Push and pop may happen together when one entry is held
    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        next_st = st;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = ~st.wr;
        end
        if (pop) begin
            next_st.rd = ~st.rd;
        end
        next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    a_buf_no_over: assert property (@(posedge clk) disable iff (!rst_n)
        st.cnt == 2'd2 |-> !in_ready)
        else $error("buffer accepts when full");
endmodule // srf_buf2
`default_nettype wire

/* File: logic/srf_uart_tx.sv */
// Asynchronous serial transmitter, 8 data bits, no parity, 1 stop bit
`timescale 1ns/1ps
`default_nettype none
module srf_uart_tx
    import srf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] baud_div,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic txd,
    output logic busy
);
    typedef struct packed {
        logic [9:0] shift;
        logic [3:0] bits;
        logic [15:0] tick;
        logic line;
    } srf_tx_st_t;

    srf_tx_st_t st, next_st;

    assign in_ready = (st.bits == 4'd0);
    assign busy = !in_ready;
    assign txd = st.line;

    // Start bit, eight data bits LSB first, one stop bit
    always_comb begin
        next_st = st;
        if (st.bits == 4'd0) begin
            next_st.line = 1'b1;
            if (in_valid) begin
                next_st.shift = {1'b1, in_data, 1'b0};
                next_st.bits = 4'd10;
                next_st.tick = 16'h0000;
            end
        end else begin
            next_st.line = st.shift[0];
            if (st.tick >= baud_div) begin
                next_st.tick = 16'h0000;
                next_st.shift = {1'b1, st.shift[9:1]};
                next_st.bits = st.bits - 4'd1;
            end else begin
                next_st.tick = st.tick + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{shift: 10'h3ff, bits: 4'd0, tick: 16'h0000, line: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    a_tx_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
        in_ready && $past(in_ready) |-> txd)
        else $error("line not idle high");
endmodule // srf_uart_tx
`default_nettype wire

/* File: logic/srf_framer.sv */
// Serial report framer: builds report frames and sends them serially
// Summary of operation
// - Characters are asynchronous, eight data bits, no parity, one stop bit.
// - Frames start only while transmit enable is on; a frame already started still finishes after it drops.
// - Order is colon, status, command, count, payload, check.
// - Header and trailer fields are single unsigned bytes.
// - Status byte is normally zero; receiver may discard non-zero.
// - Count equals payload length, zero to 255 bytes.
// - Check byte is XOR of colon through last payload byte.
// - Command selects layout; unknown commands skipped by count.
// - Char one byte, integer two, float four, long four.
// - Command 0: reading, oxygen float, range index.
// - Command 1: eight chars, flash flag, four-byte flash mask.
// - Command 2: oxygen float then temperature float.
// - Command 3: first then second loop value floats.
`timescale 1ns/1ps
`default_nettype none
module srf_framer
    import srf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_enable,
    input wire logic [15:0] baud_div,
    input wire logic req_valid,
    output logic req_ready,
    input wire srf_pkg::srf_req_t req,
    input wire srf_pkg::srf_meas_t meas,
    input wire logic ext_valid,
    output logic ext_ready,
    input wire srf_pkg::srf_byte_t ext_byte,
    output logic txd,
    output logic frame_done
);
    import srf_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef enum {
        SRF_IDLE, SRF_START, SRF_STAT, SRF_CMD, SRF_CNT, SRF_DATA, SRF_CHK,
        SRF_DRAIN
    } srf_phase_t;

    typedef struct packed {
        srf_phase_t phase;
        logic [7:0] status;
        logic [7:0] cmd;
        logic [7:0] count;
        logic [7:0] idx;
        logic [7:0] chk;
        logic [103:0] snap;
        logic ext;
        logic done;
    } srf_st_t;

    srf_st_t st, next_st;

    logic buf_ready;
    logic buf_valid_in;
    logic [7:0] buf_data_in;
    logic tx_valid;
    logic tx_ready;
    logic [7:0] tx_data;
    logic tx_busy;
    logic tx_line;

    // Documented layouts get fixed lengths; others use the requested count
    function automatic logic [7:0] layout_len(input logic [7:0] c,
                                              input logic [7:0] n);
        case (c)
            SRF_CMD_READING: layout_len = SRF_LEN_READING;
            SRF_CMD_DISPLAY: layout_len = SRF_LEN_DISPLAY;
            SRF_CMD_VALUES: layout_len = SRF_LEN_VALUES;
            SRF_CMD_LOOPS: layout_len = SRF_LEN_LOOPS;
            default: layout_len = n;
        endcase
    endfunction

    // Snapshot laid out low byte first so byte idx sits at bits idx*8
    function automatic logic [103:0] layout_pack(input logic [7:0] c,
                                                 input srf_meas_t m);
        layout_pack = '0;
        case (c)
            SRF_CMD_READING: layout_pack = {40'h0, m.range_index,
                m.oxygen_ppb, m.converter_reading};
            SRF_CMD_DISPLAY: layout_pack = {m.flash_mask, m.flash_flag,
                m.display_text};
            SRF_CMD_VALUES: layout_pack = {40'h0, m.temperature_c,
                m.oxygen_ppb};
            SRF_CMD_LOOPS: layout_pack = {40'h0, m.second_loop_value,
                m.first_loop_value};
            default: layout_pack = '0;
        endcase
    endfunction

    // Frame is documented when the command has a fixed layout
    logic cur_doc;
    assign cur_doc = (st.cmd <= SRF_CMD_LOOPS);

    // Requests taken only in idle with enable on
    assign req_ready = (st.phase == SRF_IDLE) && tx_enable;
    // External payload bytes consumed only for undocumented commands
    assign ext_ready = (st.phase == SRF_DATA) && st.ext && buf_ready;
    assign frame_done = st.done;
    assign txd = tx_line;

    // ****************************************
    // Byte sequencer
    // ****************************************
    always_comb begin
        logic [7:0] b;
        logic go;
        b = 8'h00;
        go = 1'b0;
        next_st = st;
        next_st.done = 1'b0;
        case (st.phase)
            SRF_IDLE: begin
                if (req_valid && tx_enable) begin
                    next_st.status = req.status;
                    next_st.cmd = req.cmd;
                    next_st.count = layout_len(req.cmd, req.count);
                    next_st.snap = layout_pack(req.cmd, meas);
                    next_st.ext = (req.cmd > SRF_CMD_LOOPS);
                    next_st.phase = SRF_START;
                end
            end
            SRF_START: begin
                b = SRF_START_CHAR;
                go = 1'b1;
            end
            SRF_STAT: begin
                b = st.status;
                go = 1'b1;
            end
            SRF_CMD: begin
                b = st.cmd;
                go = 1'b1;
            end
            SRF_CNT: begin
                b = st.count;
                go = 1'b1;
            end
            SRF_DATA: begin
                if (st.ext) begin
                    b = ext_byte.data;
                    go = ext_valid;
                end else begin
                    b = st.snap[7:0];
                    go = 1'b1;
                end
            end
            SRF_CHK: begin
                b = st.chk;
                go = 1'b1;
            end
            SRF_DRAIN: begin
                // Hold until the last bit leaves the line
                if (!tx_busy && !tx_valid) begin
                    next_st.phase = SRF_IDLE;
                    next_st.done = 1'b1;
                end
            end
            default: next_st.phase = SRF_IDLE;
        endcase
        if (go && buf_ready) begin
            // Check byte covers colon through last payload byte
            if (st.phase == SRF_START) begin
                next_st.chk = b;
            end else if (st.phase != SRF_CHK) begin
                next_st.chk = st.chk ^ b;
            end
            case (st.phase)
                SRF_START: next_st.phase = SRF_STAT;
                SRF_STAT: next_st.phase = SRF_CMD;
                SRF_CMD: next_st.phase = SRF_CNT;
                SRF_CNT: begin
                    next_st.idx = 8'h00;
                    next_st.phase = (st.count == 8'h00) ? SRF_CHK
                                                        : SRF_DATA;
                end
                SRF_DATA: begin
                    next_st.snap = {8'h00, st.snap[103:8]};
                    next_st.idx = st.idx + 8'h01;
                    if (st.idx + 8'h01 == st.count) begin
                        next_st.phase = SRF_CHK;
                    end
                end
                SRF_CHK: next_st.phase = SRF_DRAIN;
                default: next_st.phase = st.phase;
            endcase
        end
    end

    assign buf_valid_in = (st.phase == SRF_START) || (st.phase == SRF_STAT)
        || (st.phase == SRF_CMD) || (st.phase == SRF_CNT)
        || (st.phase == SRF_CHK)
        || ((st.phase == SRF_DATA) && (!st.ext || ext_valid));
    assign buf_data_in = (st.phase == SRF_START) ? SRF_START_CHAR
        : (st.phase == SRF_STAT) ? st.status
        : (st.phase == SRF_CMD) ? st.cmd
        : (st.phase == SRF_CNT) ? st.count
        : (st.phase == SRF_CHK) ? st.chk
        : st.ext ? ext_byte.data : st.snap[7:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{phase: SRF_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Buffer and transmitter
    // ****************************************
    // Buffer absorbs transmitter stalls so no byte is dropped
    srf_buf2 u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(buf_valid_in),
        .in_ready(buf_ready),
        .in_data(buf_data_in),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    srf_uart_tx u_tx (
        .clk(clk),
        .rst_n(rst_n),
        .baud_div(baud_div),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .txd(tx_line),
        .busy(tx_busy)
    );

    // ****************************************
    // Checks
    // ****************************************
    logic [7:0] chk_model;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_model <= 8'h00;
        end else if (buf_valid_in && buf_ready) begin
            if (st.phase == SRF_START) begin
                chk_model <= buf_data_in;
            end else if (st.phase != SRF_CHK) begin
                chk_model <= chk_model ^ buf_data_in;
            end
        end
    end

    a_chk_byte_xor: assert property (@(posedge clk) disable iff (!rst_n)
        (st.phase == SRF_CHK && buf_valid_in) |-> buf_data_in == chk_model)
        else $error("check byte mismatch");
    a_first_is_colon: assert property (@(posedge clk) disable iff (!rst_n)
        (st.phase == SRF_START) |-> buf_data_in == SRF_START_CHAR)
        else $error("frame does not start with colon");
    a_colon_then_stat: assert property (@(posedge clk) disable iff (!rst_n)
        (st.phase == SRF_START && buf_ready) |=> st.phase == SRF_STAT)
        else $error("status does not follow colon");
    a_no_req_off: assert property (@(posedge clk) disable iff (!rst_n)
        !tx_enable |-> !req_ready)
        else $error("frame accepted while disabled");
    a_len_reading: assert property (@(posedge clk) disable iff (!rst_n)
        (st.phase == SRF_CNT && st.cmd == SRF_CMD_READING)
        |-> st.count == 8'h08)
        else $error("wrong command zero length");
    a_len_display: assert property (@(posedge clk) disable iff (!rst_n)
        (st.phase == SRF_CNT && st.cmd == SRF_CMD_DISPLAY)
        |-> st.count == 8'h0d)
        else $error("wrong command one length");
    a_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
        (st.phase == SRF_DATA) |-> st.idx < st.count)
        else $error("payload overruns count");
    a_empty_skips: assert property (@(posedge clk) disable iff (!rst_n)
        (st.phase == SRF_CNT && st.count == 8'h00 && buf_ready)
        |=> st.phase == SRF_CHK)
        else $error("empty payload not skipped");

    c_frame_done: cover property (@(posedge clk) disable iff (!rst_n)
        frame_done);
    c_ext_frame: cover property (@(posedge clk) disable iff (!rst_n)
        st.ext && st.phase == SRF_CHK);
    c_stall: cover property (@(posedge clk) disable iff (!rst_n)
        buf_valid_in && !buf_ready);
    c_doc_frame: cover property (@(posedge clk) disable iff (!rst_n)
        cur_doc && st.phase == SRF_CHK);
endmodule // srf_framer
`default_nettype wire

/* File: test/srf_host_model.sv */
// Host model: serial receiver and report frame parser
`timescale 1ns/1ps
`default_nettype none
module srf_host_model
    import srf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic txd,
    input wire logic [15:0] baud_div,
    output logic byte_stb,
    output logic [7:0] byte_data,
    output logic [15:0] good_cnt,
    output logic [15:0] bad_cnt
);
    logic [7:0] sh;
    logic [7:0] acc;
    int idx = 0;
    int need = 0;

    initial begin
        good_cnt = 16'h0000;
        bad_cnt = 16'h0000;
        byte_stb = 1'b0;
        byte_data = 8'h00;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Parser: frame end found by count, status ignored
    task automatic take(input logic [7:0] b);
        if (idx == 0 && b !== 8'h3a) begin
            bad_cnt = bad_cnt + 16'h0001;
        end else if (idx == 4 + need) begin
            if (b === acc)
                good_cnt = good_cnt + 16'h0001;
            else
                bad_cnt = bad_cnt + 16'h0001;
            idx = 0;
        end else begin
            acc = (idx == 0) ? b : acc ^ b;
            if (idx == 3)
                need = int'(b);
            idx = idx + 1;
        end
    endtask

    // Receiver samples mid-bit; a broken stop bit is counted, not kept
    always begin : rx_loop
        @(posedge clk);
        if (rst_n === 1'b1 && txd === 1'b0) begin
            wait_clk((int'(baud_div) + 1) / 2);
            for (int i = 0; i < 8; i++) begin
                wait_clk(int'(baud_div) + 1);
                sh[i] = txd;
            end
            wait_clk(int'(baud_div) + 1);
            if (txd !== 1'b1) begin
                bad_cnt = bad_cnt + 16'h0001;
            end else begin
                byte_data <= sh;
                byte_stb <= 1'b1;
                take(sh);
                @(posedge clk);
                byte_stb <= 1'b0;
            end
        end
    end

    // Reset drops any half-received character
    always @(negedge rst_n) begin
        disable rx_loop;
        idx = 0;
        byte_stb <= 1'b0;
    end
endmodule // srf_host_model
`default_nettype wire

/* File: test/tb_serial_report_framer.sv */
// Testbench for the serial report framer
`timescale 1ns/1ps
`default_nettype none
module tb_serial_report_framer;
    import srf_pkg::*;
    // ****************************************
    // Stimulus and results
    // ****************************************
    localparam logic [15:0] DIV = 16'h0003; // Short bits keep runs brief
    localparam int LIM = 20000;
    localparam srf_meas_t M1 = '{16'h1234, 32'h4148f5c3, 16'h0003,
        64'h0031_2e35_3520_2020, 8'h01, 32'h0000f00f, 32'h41c80000,
        32'h40800000, 32'h41a00000};
    typedef struct {logic [7:0] cmd; logic [7:0] len; bit inv;} srf_row_t;
    srf_row_t rows [8] = '{'{8'h00, 8'h08, 0}, '{8'h01, 8'h0d, 0},
        '{8'h02, 8'h08, 0}, '{8'h03, 8'h08, 0}, '{8'h00, 8'h08, 1},
        '{8'h01, 8'h0d, 1}, '{8'h02, 8'h08, 1}, '{8'h03, 8'h08, 1}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tx_enable = 1'b1;
    logic req_valid = 1'b0;
    logic ext_valid = 1'b0;
    srf_req_t req = '0;
    srf_meas_t meas = '0;
    srf_byte_t ext_byte = '0;
    logic req_ready, ext_ready, txd, frame_done, byte_stb;
    logic [7:0] byte_data;
    logic [15:0] good_cnt, bad_cnt, good_base;
    int n_mismatch = 0;
    int comparisons = 0;
    int tick = 0;
    logic [7:0] exp_q [$];
    logic [7:0] got_q [$];
    logic [7:0] pay_q [$];
    logic [7:0] src_q [$];

    always #10 clk = ~clk;

    srf_framer i_srf_framer (.clk(clk), .rst_n(rst_n),
        .tx_enable(tx_enable), .baud_div(DIV), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .meas(meas),
        .ext_valid(ext_valid), .ext_ready(ext_ready),
        .ext_byte(ext_byte), .txd(txd), .frame_done(frame_done));
    srf_host_model i_srf_host_model (.clk(clk), .rst_n(rst_n), .txd(txd),
        .baud_div(DIV), .byte_stb(byte_stb), .byte_data(byte_data),
        .good_cnt(good_cnt), .bad_cnt(bad_cnt));

    // Collect what the host received
    always @(posedge clk) begin
        if (byte_stb === 1'b1)
            got_q.push_back(byte_data);
    end

    // Payload source stalls every third slot, holds data until taken
    always @(posedge clk) begin
        if (ext_valid && ext_ready === 1'b1)
            void'(src_q.pop_front());
        if (!ext_valid || ext_ready === 1'b1) begin
            tick = tick + 1;
            if (src_q.size() != 0 && tick % 3 != 0) begin
                ext_valid <= 1'b1;
                ext_byte <= '{src_q[0], src_q.size() == 1};
            end else begin
                ext_valid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Checking tasks
    // ****************************************
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_count(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wrap_up();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic add16(input logic [15:0] v);
        pay_q.push_back(v[7:0]);
        pay_q.push_back(v[15:8]);
    endtask

    task automatic add32(input logic [31:0] v);
        add16(v[15:0]);
        add16(v[31:16]);
    endtask

    // Expected payload per layout; other commands come from the source
    task automatic build(input logic [7:0] cmd, input srf_meas_t m);
        pay_q.delete();
        case (cmd)
            8'h00: begin
                add16(m.converter_reading);
                add32(m.oxygen_ppb);
                add16(m.range_index);
            end
            8'h01: begin
                for (int k = 0; k < 8; k++)
                    pay_q.push_back(m.display_text[8*k+:8]);
                pay_q.push_back(m.flash_flag);
                add32(m.flash_mask);
            end
            8'h02: begin
                add32(m.oxygen_ppb);
                add32(m.temperature_c);
            end
            8'h03: begin
                add32(m.first_loop_value);
                add32(m.second_loop_value);
            end
            default: pay_q = src_q;
        endcase
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < LIM);
        // A request that is never taken ends the run as a failure
        if (req_ready !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    // One frame; gate holds enable low first, then drops it mid-frame
    task automatic send(input logic [7:0] st, input logic [7:0] cmd,
            input logic [7:0] cnt, input srf_meas_t m, input bit gate);
        logic [7:0] x;
        int n;
        build(cmd, m);
        exp_q = {8'h3a, st, cmd, cnt};
        exp_q = {exp_q, pay_q};
        x = 8'h00;
        foreach (exp_q[k])
            x = x ^ exp_q[k];
        exp_q.push_back(x);
        got_q.delete();
        good_base = good_cnt;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{st, cmd, cnt};
        meas <= m;
        if (gate) begin
            tx_enable <= 1'b0;
            n = 0;
            repeat (100) begin
                @(negedge clk);
                if (req_ready !== 1'b0 || txd !== 1'b1)
                    n++;
            end
            chk_count(16'(n), 16'h0000);
            @(posedge clk);
            tx_enable <= 1'b1;
        end
        wait_ready();
        @(posedge clk);
        req_valid <= 1'b0;
        if (gate)
            tx_enable <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (frame_done !== 1'b1 && n < LIM);
        if (n >= LIM) begin
            n_mismatch++;
            wrap_up();
        end
        repeat (8) @(negedge clk);
        chk_count(16'(got_q.size()), 16'(exp_q.size()));
        foreach (exp_q[k])
            chk_byte(got_q[k], exp_q[k]);
        chk_count(good_cnt - good_base, 16'h0001);
        if (gate) begin
            @(posedge clk);
            tx_enable <= 1'b1;
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[r])
            send(8'h00, rows[r].cmd, rows[r].len,
                rows[r].inv ? ~M1 : M1, 1'b0);
        // Unknown command, empty payload, enable gated
        send(8'h00, 8'h07, 8'h00, M1, 1'b1);
        // Longest payload through a stalling source
        for (int k = 0; k < 255; k++)
            src_q.push_back(8'(k) ^ 8'h5a);
        send(8'h00, 8'hc5, 8'hff, M1, 1'b0);
        send(8'h5a, 8'h02, 8'h08, M1, 1'b0);
        // Reset in mid-frame returns the line to idle
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{8'h00, 8'h03, 8'h08};
        wait_ready();
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (150) @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(negedge clk);
        chk_byte({7'h00, txd}, 8'h01);
        chk_byte({7'h00, frame_done}, 8'h00);
        chk_byte({7'h00, req_ready}, 8'h01);
        @(posedge clk);
        rst_n <= 1'b1;
        send(8'h00, 8'h01, 8'h0d, ~M1, 1'b0);
        // No broken character or frame over the whole run
        chk_count(bad_cnt, 16'h0000);
        wrap_up();
    end
endmodule // tb_serial_report_framer
`default_nettype wire
